// [dmx_exec.sv]
/*
 * Decode and execute of four data-move instructions: pointer literal
 * load, register move, memory-to-memory copy, bank literal load.
 * Assumes fetch and data memory sit on the same clock; memory answers a
 * read combinationally within the cycle that the read strobe stands.
 */
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module dmx_exec #(
    parameter logic [11:0] ACC_ADDR = 12'hfe8
) (
    input  wire logic                  mclk_i,
    input  wire logic                  srst_i,
    input  wire dmx_pkg::dmx_fetch_t   fetch_i,
    output logic                       fetch_ready_o,
    output dmx_pkg::dmx_mem_req_t      mem_req_o,
    input  wire logic [7:0]            mem_rdata_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o
);
    import dmx_pkg::*;

    logic [PHASE_COUNT-1:0] q_en;
    dmx_state_t             state;
    dmx_op_t                op;
    dmx_op_t                next_op;
    logic [15:0]            ir;
    logic                   take;
    logic [7:0]             acc;
    logic [7:0]             bank_select_register;
    logic [3:0]             ptr_hi [PTR_COUNT];
    logic [7:0]             ptr_lo [PTR_COUNT];
    logic [11:0]            ptr_indexed;
    logic [1:0]             ptr_sel;
    logic [7:0]             move_byte;
    logic                   flag_neg;
    logic                   flag_zero;
    logic                   ext_en;
    logic [11:0]            move_addr;
    logic [11:0]            bank_addr;
    logic [11:0]            index_addr;
    logic [7:0]             f_field;

    dmx_qphase u_qphase (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .q_en_o (q_en)
    );

    // fetch handshake: a word is taken only in Q1
    assign fetch_ready_o = q_en[PH_Q1];
    assign take          = q_en[PH_Q1] & fetch_i.valid;

    always_comb begin
        next_op = DMX_OP_NOP;
        if (take) begin
            case (state)
                DMX_ST_FIRST: begin
                    if (fetch_i.word[15:6] == PTR_W1_TOP) begin
                        next_op = DMX_OP_PTR_HI;
                    end else if (fetch_i.word[15:10] == MOVE_TOP) begin
                        next_op = DMX_OP_MOVE;
                    end else if (fetch_i.word[15:12] == COPY_W1_TOP) begin
                        next_op = DMX_OP_COPY_SRC;
                    end else if (fetch_i.word[15:4] == BANK_TOP) begin
                        next_op = DMX_OP_BANK;
                    end
                end
                DMX_ST_PTR_LO: begin
                    if (fetch_i.word[15:8] == PTR_W2_TOP) begin
                        next_op = DMX_OP_PTR_LO;
                    end
                end
                DMX_ST_COPY_DST: begin
                    if (fetch_i.word[15:12] == COPY_W2_TOP) begin
                        next_op = DMX_OP_COPY_DST;
                    end
                end
                default: next_op = DMX_OP_NOP;
            endcase
        end
    end

    // word sequencing; a missing word just stretches the cycle count
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state <= DMX_ST_FIRST;
        end else if (take) begin
            case (next_op)
                DMX_OP_PTR_HI:   state <= DMX_ST_PTR_LO;
                DMX_OP_COPY_SRC: state <= DMX_ST_COPY_DST;
                default:         state <= DMX_ST_FIRST;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            op <= DMX_OP_NOP;
            ir <= 16'h0000;
        end else if (q_en[PH_Q1]) begin
            op <= next_op;
            ir <= take ? fetch_i.word : 16'h0000;
        end
    end

    // register-move address formation
    assign f_field     = fetch_i.word[7:0];
    assign ptr_indexed = {ptr_hi[PTR_INDEXED], ptr_lo[PTR_INDEXED]};
    assign bank_addr   = {bank_select_register[3:0], f_field};
    assign index_addr  = ptr_indexed + {4'h0, f_field};

    always_comb begin
        if (fetch_i.word[F_ACCESS]) begin
            move_addr = bank_addr;
        end else if (ext_en && f_field <= EXT_MAX_F) begin
            move_addr = index_addr;
        end else if (f_field <= EXT_MAX_F) begin
            move_addr = {BANK_HI_ZERO, f_field};
        end else begin
            move_addr = {ACC_HI_BANK, f_field};
        end
    end

    // data memory strobes: read shown in Q2, write shown in Q4
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mem_req_o <= '0;
        end else begin
            mem_req_o.rd <= 1'b0;
            mem_req_o.wr <= 1'b0;
            if (take && next_op == DMX_OP_MOVE) begin
                mem_req_o.rd   <= 1'b1;
                mem_req_o.addr <= move_addr;
            end else if (take && next_op == DMX_OP_COPY_SRC &&
                         fetch_i.word[11:0] != ACC_ADDR) begin
                mem_req_o.rd   <= 1'b1;
                mem_req_o.addr <= fetch_i.word[11:0];
            end
            if (q_en[PH_Q3] && op == DMX_OP_MOVE && ir[F_DEST]) begin
                mem_req_o.wr    <= 1'b1;
                mem_req_o.wdata <= move_byte;
            end else if (q_en[PH_Q3] && op == DMX_OP_COPY_DST &&
                         ir[11:0] != ACC_ADDR) begin
                mem_req_o.wr    <= 1'b1;
                mem_req_o.addr  <= ir[11:0];
                mem_req_o.wdata <= move_byte;
            end
        end
    end

    // source byte caught at the end of Q2; held over for the copy's 2nd word
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            move_byte <= 8'h00;
        end else if (q_en[PH_Q2] && op == DMX_OP_MOVE) begin
            move_byte <= mem_rdata_i;
        end else if (q_en[PH_Q2] && op == DMX_OP_COPY_SRC) begin
            move_byte <= (ir[11:0] == ACC_ADDR) ? acc
                                                : mem_rdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            acc <= 8'h00;
        end else if (q_en[PH_Q4]) begin
            if (op == DMX_OP_MOVE && !ir[F_DEST]) begin
                acc <= move_byte;
            end else if (op == DMX_OP_COPY_DST && ir[11:0] == ACC_ADDR) begin
                acc <= move_byte;
            end
        end
    end

    // only the register move touches the flags
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            flag_neg  <= 1'b0;
            flag_zero <= 1'b0;
        end else if (q_en[PH_Q4] && op == DMX_OP_MOVE) begin
            flag_neg  <= move_byte[7];
            flag_zero <= (move_byte == 8'h00);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bank_select_register <= 8'h00;
        end else if (q_en[PH_Q4] && op == DMX_OP_BANK) begin
            bank_select_register <= {BANK_HI_ZERO, ir[3:0]};
        end
    end

    // select kept from the first word for the second
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ptr_sel <= 2'h0;
        end else if (q_en[PH_Q4] && op == DMX_OP_PTR_HI) begin
            ptr_sel <= ir[F_PSEL_HI:F_PSEL_LO];
        end
    end

    genvar p;
    generate
        for (p = 0; p < PTR_COUNT; p++) begin : g_ptr
            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    ptr_hi[p] <= 4'h0;
                    ptr_lo[p] <= 8'h00;
                end else if (q_en[PH_Q4]) begin
                    if (op == DMX_OP_PTR_HI &&
                        ir[F_PSEL_HI:F_PSEL_LO] == 2'(p)) begin
                        ptr_hi[p] <= ir[3:0];
                    end
                    if (op == DMX_OP_PTR_LO && ptr_sel == 2'(p)) begin
                        ptr_lo[p] <= ir[7:0];
                    end
                end
            end
        end
    endgenerate

    // wishbone slave, one wait state, unmapped reads return zero
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ext_en <= EXT_RESET;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
                     wb_sel_i[0] && wb_adr_i == REG_CTRL) begin
            ext_en <= wb_dat_i[CTRL_EXT];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i)
                REG_CTRL:   wb_dat_o[CTRL_EXT] <= ext_en;
                REG_STATUS: begin
                    wb_dat_o[7:0]                       <= acc;
                    wb_dat_o[ST_BANK_LSB+7:ST_BANK_LSB] <= bank_select_register;
                    wb_dat_o[ST_ZERO]                   <= flag_zero;
                    wb_dat_o[ST_NEG]                    <= flag_neg;
                end
                REG_PTR0:   wb_dat_o[11:0] <= {ptr_hi[0], ptr_lo[0]};
                REG_PTR1:   wb_dat_o[11:0] <= {ptr_hi[1], ptr_lo[1]};
                REG_PTR2:   wb_dat_o[11:0] <= ptr_indexed;
                default:    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    sequence s_copy_dst_q3;
        op == DMX_OP_COPY_DST && q_en[PH_Q3] && ir[11:0] != ACC_ADDR;
    endsequence
    sequence s_copy_write;
        mem_req_o.wr && !mem_req_o.rd && q_en[PH_Q4];
    endsequence

    a_ptr_high_load: assert property (
        q_en[PH_Q4] && op == DMX_OP_PTR_HI &&
        ir[F_PSEL_HI:F_PSEL_LO] == 2'h0 |=> ptr_hi[0] == $past(ir[3:0]))
        else $error("pointer high part not loaded");
    a_ptr_sel_range: assert property (
        q_en[PH_Q4] && op == DMX_OP_PTR_LO && ptr_sel > PTR_SEL_MAX
        |=> $stable(ptr_indexed))
        else $error("invalid pointer select changed a pointer");
    a_read_in_q2: assert property (
        mem_req_o.rd |-> q_en[PH_Q2] && (op == DMX_OP_MOVE ||
                                          op == DMX_OP_COPY_SRC))
        else $error("memory read outside Q2");
    a_move_to_acc: assert property (
        q_en[PH_Q2] && op == DMX_OP_MOVE && !ir[F_DEST]
        |=> ##2 acc == $past(mem_rdata_i, 3))
        else $error("moved byte missing from accumulator");
    a_move_write_back: assert property (
        q_en[PH_Q3] && op == DMX_OP_MOVE && ir[F_DEST]
        |=> mem_req_o.wr && mem_req_o.wdata == $past(move_byte))
        else $error("write back to source missing");
    a_bank_addr_form: assert property (
        take && next_op == DMX_OP_MOVE && fetch_i.word[F_ACCESS]
        |=> mem_req_o.rd && mem_req_o.addr == $past(bank_addr))
        else $error("banked address wrong");
    a_indexed_addr: assert property (
        take && next_op == DMX_OP_MOVE && !fetch_i.word[F_ACCESS] &&
        ext_en && f_field <= EXT_MAX_F
        |=> mem_req_o.addr == $past(index_addr))
        else $error("indexed offset address wrong");
    a_copy_dst_write: assert property (
        s_copy_dst_q3 |=> s_copy_write)
        else $error("copy destination write missing");
    a_copy_to_acc: assert property (
        q_en[PH_Q4] && op == DMX_OP_COPY_DST && ir[11:0] == ACC_ADDR
        |=> acc == $past(move_byte) && !$past(mem_req_o.wr))
        else $error("copy into accumulator wrong");
    a_bank_nibble: assert property (
        q_en[PH_Q4] && op == DMX_OP_BANK
        |=> bank_select_register == {BANK_HI_ZERO, $past(ir[3:0])})
        else $error("bank select load wrong");
    a_flags_hold: assert property (
        q_en[PH_Q4] && op != DMX_OP_MOVE
        |=> $stable(flag_neg) && $stable(flag_zero))
        else $error("flags changed by a non-move op");

endmodule

// [dmx_pkg.sv]
/*
 * Shared constants, carrier structs and enumerations for the data-move
 * executor: opcode patterns, quarter-phase indices, register offsets of
 * the Wishbone slave, status field positions.
 * Assumes a single 40 MHz core clock and 16-bit instruction words.
 */
package dmx_pkg;

    // core clock and instruction cycle shape
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          PHASE_COUNT   = 4;
    localparam int          PH_Q1         = 0;
    localparam int          PH_Q2         = 1;
    localparam int          PH_Q3         = 2;
    localparam int          PH_Q4         = 3;

    // opcode patterns
    localparam logic [9:0]  PTR_W1_TOP    = 10'h3b8;  // 1110 1110 00
    localparam logic [7:0]  PTR_W2_TOP    = 8'hf0;    // 1111 0000
    localparam logic [5:0]  MOVE_TOP      = 6'h14;    // 0101 00
    localparam logic [3:0]  COPY_W1_TOP   = 4'hc;
    localparam logic [3:0]  COPY_W2_TOP   = 4'hf;
    localparam logic [11:0] BANK_TOP      = 12'h010;  // 0000 0001 0000

    // instruction field positions
    localparam int          F_DEST        = 9;
    localparam int          F_ACCESS      = 8;
    localparam int          F_PSEL_HI     = 5;
    localparam int          F_PSEL_LO     = 4;

    // addressing
    localparam int          PTR_COUNT     = 3;
    localparam int          PTR_INDEXED   = 2;
    localparam logic [1:0]  PTR_SEL_MAX   = 2'h2;
    localparam logic [7:0]  EXT_MAX_F     = 8'h5f;
    localparam logic [3:0]  ACC_HI_BANK   = 4'hf;
    localparam logic [3:0]  BANK_HI_ZERO  = 4'h0;

    // register map, byte offsets
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_PTR0      = 8'h08;
    localparam logic [7:0]  REG_PTR1      = 8'h0c;
    localparam logic [7:0]  REG_PTR2      = 8'h10;
    localparam int          CTRL_EXT      = 0;
    localparam int          ST_BANK_LSB   = 8;
    localparam int          ST_ZERO       = 16;
    localparam int          ST_NEG        = 17;
    localparam logic        EXT_RESET     = 1'b0;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } dmx_fetch_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } dmx_mem_req_t;

    typedef enum logic [1:0] {
        DMX_ST_FIRST,
        DMX_ST_PTR_LO,
        DMX_ST_COPY_DST
    } dmx_state_t;

    typedef enum logic [2:0] {
        DMX_OP_NOP,
        DMX_OP_PTR_HI,
        DMX_OP_PTR_LO,
        DMX_OP_MOVE,
        DMX_OP_COPY_SRC,
        DMX_OP_COPY_DST,
        DMX_OP_BANK
    } dmx_op_t;

endpackage

// [dmx_qphase.sv]
/*
 * Quarter-phase divider: one-hot enables, one clock each, Q1..Q4.
 * Assumes synchronous active-high reset; Q1 is the first cycle after it.
 */
`timescale 1ns/1ps
module dmx_qphase (
    input  wire logic                         mclk_i,
    input  wire logic                         srst_i,
    output logic [dmx_pkg::PHASE_COUNT-1:0]   q_en_o
);
    import dmx_pkg::*;

    logic [1:0] cnt;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < PHASE_COUNT; i++) begin : g_ph
            assign q_en_o[i] = (cnt == 2'(i));
        end
    endgenerate

endmodule

// [dmx_mem_model.sv]
/*
 * Data memory partner of the data-move executor: 4096 bytes, read
 * answered combinationally while the read strobe stands, write at the
 * edge ending the write strobe cycle.
 * Assumes the executor's request struct and the single core clock.
 */
`timescale 1ns/1ps
module dmx_mem_model (
    input  wire logic                  mclk_i,
    input  wire dmx_pkg::dmx_mem_req_t mem_req_i,
    output logic [7:0]                 mem_rdata_o
);
    import dmx_pkg::*;

    logic [7:0] mem [4096];  // full data space 000h..fffh
    logic [7:0] last = 8'h00;

    // undriven bus shows inverse of last byte, never a stale match
    always_comb mem_rdata_o = mem_req_i.rd ? mem[mem_req_i.addr] : ~last;

    always @(posedge mclk_i) begin
        if (mem_req_i.rd) begin
            last <= mem[mem_req_i.addr];
        end
        if (mem_req_i.wr) begin
            mem[mem_req_i.addr] <= mem_req_i.wdata;
        end
    end
endmodule

// [data_move_instruction_exec_tb.sv]
/*
 * Self-checking bench of the data-move executor against a reference
 * model of pointers, bank select, accumulator, flags and memory.
 * Assumes the memory partner model and a Wishbone view of the state.
 */
`timescale 1ns/1ps
module data_move_instruction_exec_tb;
    import dmx_pkg::*;

    localparam logic [11:0] ACC = 12'hfe8;
    logic        mclk_i = 1'b0;
    logic        srst_i = 1'b1;
    dmx_fetch_t  fetch_i = '0;
    logic        fetch_ready_o;
    dmx_mem_req_t req;
    logic [7:0]  rdata;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we  = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [31:0] seed = 32'hc9fe;
    logic [31:0] tmp;
    logic [7:0]  rm [4096];
    logic [7:0]  racc = 8'h00;
    logic [7:0]  rbank = 8'h00;
    logic        rn = 1'b0;
    logic        rz = 1'b0;
    logic        rext = 1'b0;
    logic [11:0] rptr [3] = '{12'h0, 12'h0, 12'h0};
    logic [11:0] lr_addr = 12'h0;
    logic [11:0] lw_addr = 12'h0;
    logic [7:0]  lw_data = 8'h0;
    int          cnt = 0;
    int          t_rd = 0;
    int          t_wr = 0;
    int          t_take = 0;
    int          n_rd = 0;
    int          n_wr = 0;
    int          n_fail = 0;
    int          checks = 0;

    always #12.5 mclk_i = ~mclk_i;

    dmx_exec #(.ACC_ADDR(ACC)) dut (
        .mclk_i(mclk_i), .srst_i(srst_i), .fetch_i(fetch_i),
        .fetch_ready_o(fetch_ready_o), .mem_req_o(req),
        .mem_rdata_i(rdata), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    dmx_mem_model u (.mclk_i(mclk_i), .mem_req_i(req), .mem_rdata_o(rdata));

    always @(posedge mclk_i) begin
        cnt <= cnt + 1;
        if (req.rd === 1'b1) begin
            t_rd <= cnt; lr_addr <= req.addr; n_rd <= n_rd + 1;
        end
        if (req.wr === 1'b1) begin
            t_wr <= cnt; lw_addr <= req.addr; lw_data <= req.wdata;
            n_wr <= n_wr + 1;
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wb(logic we, logic [7:0] adr, logic [31:0] d,
                      output logic [31:0] q);
        @(posedge mclk_i);
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we;
        wb_adr <= adr; wb_sel <= 4'hf; wb_dat <= d;
        // request held until the rising edge that sees ack high
        do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rdreg(string nm, logic [7:0] adr, logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, adr, 32'h0, q);
        chk(nm, q, exp);
    endtask

    task automatic rd_st();
        rdreg("status", REG_STATUS, {14'h0, rn, rz, rbank, racc});
    endtask

    task automatic issue(logic [15:0] w);
        @(posedge mclk_i);
        fetch_i <= '{valid: 1'b1, word: w};
        // word taken at the rising edge that samples ready high
        do @(posedge mclk_i); while (fetch_ready_o !== 1'b1);
        t_take = cnt;
        fetch_i.valid <= 1'b0;
    endtask

    task automatic settle();
        repeat (4) @(posedge mclk_i);
    endtask

    task automatic do_move(logic d, logic a, logic [7:0] f);
        logic [11:0] ad;
        logic [7:0]  b;
        int          w0;
        if (a) ad = {rbank[3:0], f};
        else if (rext && f <= EXT_MAX_F) ad = rptr[2] + 12'(f);
        else ad = (f <= EXT_MAX_F) ? 12'(f) : {4'hf, f};
        b = rm[ad]; rz = (b == 8'h00); rn = b[7];
        if (!d) racc = b;
        w0 = n_wr;
        issue({MOVE_TOP, d, a, f});
        settle();
        chk("move rd phase", 32'(t_rd - t_take), 32'd1);
        chk("move rd addr", 32'(lr_addr), 32'(ad));
        chk("move wr count", 32'(n_wr - w0), 32'(d));
        if (d) begin
            chk("move wr addr", 32'(lw_addr), 32'(ad));
            chk("move wr data", 32'(lw_data), 32'(b));
            chk("move wr phase", 32'(t_wr - t_take), 32'd3);
        end
        rd_st();
    endtask

    task automatic do_copy(logic [11:0] s, logic [11:0] dd);
        logic [7:0] b;
        int         r0;
        int         w0;
        b = (s == ACC) ? racc : rm[s];
        if (dd == ACC) racc = b;
        else rm[dd] = b;
        r0 = n_rd; w0 = n_wr;
        issue({COPY_W1_TOP, s});
        issue({COPY_W2_TOP, dd});
        settle();
        chk("copy rd count", 32'(n_rd - r0), 32'(s != ACC));
        chk("copy wr count", 32'(n_wr - w0), 32'(dd != ACC));
        if (dd != ACC) begin
            chk("copy wr addr", 32'(lw_addr), 32'(dd));
            chk("copy wr phase", 32'(t_wr - t_take), 32'd3);
            chk("copy mem", 32'(u.mem[dd]), 32'(b));
        end
        rd_st();
    endtask

    task automatic do_ptr(logic [1:0] sel, logic [11:0] k);
        logic [11:0] old;
        old = (sel < 2'd3) ? rptr[sel] : 12'h0;
        issue({PTR_W1_TOP, sel, k[11:8]});
        settle();
        if (sel < 2'd3) begin
            rdreg("ptr high", REG_PTR0 + 8'(4 * sel),
                  32'({k[11:8], old[7:0]}));
            rptr[sel] = k;
        end
        issue({PTR_W2_TOP, k[7:0]});
        settle();
        for (int i = 0; i < 3; i++) begin
            rdreg("ptr", REG_PTR0 + 8'(4 * i), 32'(rptr[i]));
        end
        rd_st();
    endtask

    initial begin
        for (int i = 0; i < 4096; i++) begin
            tmp = xs(); u.mem[i] = tmp[7:0]; rm[i] = tmp[7:0];
        end
        u.mem[5] = 8'h00; rm[5] = 8'h00;
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b0;
        rdreg("ctrl reset", REG_CTRL, 32'h0);
        rd_st();
        rdreg("unmapped", 8'h20, 32'h0);
        wb(1'b1, REG_STATUS, 32'hffffffff, tmp);
        rd_st();
        $display("test registers done");
        for (int k = 0; k < 16; k++) begin
            rbank = 8'(k);
            issue({BANK_TOP, 4'(k)});
            settle();
            rd_st();
        end
        $display("test bank load done");
        for (int s = 0; s < 4; s++) begin
            tmp = xs();
            do_ptr(2'(s), (s == 2) ? 12'h3ab : tmp[11:0]);
        end
        // mismatched second word: consumed as a no-op, low byte kept
        issue({PTR_W1_TOP, 2'h1, 4'h7});
        issue({BANK_TOP, 4'h3});
        settle();
        rptr[1][11:8] = 4'h7;
        rdreg("ptr dropped", REG_PTR1, 32'(rptr[1]));
        rd_st();
        $display("test pointer load done");
        do_move(1'b0, 1'b0, 8'h05);
        for (int i = 0; i < 16; i++) begin
            tmp = xs();
            if (i == 8) begin
                wb(1'b1, REG_CTRL, 32'h1, tmp);
                rext = 1'b1;
                rdreg("ctrl ext", REG_CTRL, 32'h1);
            end
            if (i % 8 == 4) do_move(tmp[0], 1'b0, 8'h5f);
            else if (i % 8 == 5) do_move(tmp[0], 1'b0, 8'h60);
            else do_move(tmp[0], tmp[1], tmp[15:8]);
        end
        $display("test register move done");
        do_copy(12'h000, 12'hfff);
        do_copy(ACC, 12'h123);
        do_copy(12'h456, ACC);
        for (int i = 0; i < 6; i++) begin
            tmp = xs();
            // stay below the control-byte area
            do_copy(tmp[11:0], 12'(tmp[23:12] % 12'hf80));
        end
        $display("test memory copy done");
        test_done();
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        n_fail++;
        test_done();
    end
endmodule
